/* verilog/sep_pkg.sv */
// Purpose: Shared constants and types of the serial memory slave
// Assumes: 10 MHz system clock
// Notes: Link side runs on the serial clock itself
package sep_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_WR_NS = 5000000;
    // Longest time, so the division rounds down
    localparam int WR_CYCLES = T_WR_NS / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // Framing and layout
    // ------------------------------------------------------------
    localparam logic [3:0] DEV_TYPE = 4'ha;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam int PAGE_BYTES = 8;
    localparam int MEM_WORDS = 256;
    localparam int SYNC_W = 6;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic OE_N_RST = 1'b1;
    localparam logic [15:0] CNT_STEP = 16'h0001;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEVADDR = 3'b001,
        ST_WORDADDR = 3'b010,
        ST_WRDATA = 3'b011,
        ST_RDDATA = 3'b100
    } sep_state_e;
endpackage

/* verilog/sep_prog_if.sv */
// Purpose: Page hand-off between link logic and programming engine
// Assumes: Page fields stay still while the engine is busy
// Notes: Toggles carry the events, the page words ride along
`timescale 1ns/1ns
interface sep_prog_if;
    logic [7:0][7:0] page_data;
    logic [7:0] page_mask;
    logic [4:0] page_row;
    logic wr_tog;
    logic done_tog;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    modport ctrl (
        output page_data, page_mask, page_row, wr_tog, rd_addr,
        input done_tog, rd_data
    );
    modport prog (
        input page_data, page_mask, page_row, wr_tog, rd_addr,
        output done_tog, rd_data
    );
endinterface

/* verilog/sep_sync2.sv */
// Purpose: Two-stage synchroniser for a bundle of levels
// Assumes: Each bit changes slowly against the receiving clock
// Notes: First stage feeds only the second
`timescale 1ns/1ns
module sep_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Levels
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_r <= '0;
            q_out <= '0;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule // sep_sync2

/* verilog/sep_prog.sv */
// Purpose: Array and self-timed programming cycle
// Assumes: Page words are stable from the write toggle until done
// Notes: Bytes land at the start of the cycle; reads are blocked meanwhile
`timescale 1ns/1ns
module sep_prog #(
    parameter int WR_CYC = sep_pkg::WR_CYCLES
) (
    // System clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Page hand-off
    sep_prog_if.prog pif
);
    import sep_pkg::*;
    localparam logic [15:0] CNT_LAST = 16'(WR_CYC - 1);
    logic [7:0] mem [MEM_WORDS];
    logic wr_s;
    logic seen_r;
    logic busy_r;
    logic done_r;
    logic [15:0] cnt_r;
    wire go = (wr_s != seen_r) && !busy_r;
    sep_sync2 #(.W(1)) u_wr_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(pif.wr_tog),
        .q_out(wr_s)
    );
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            seen_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            cnt_r <= 16'h0000;
        end else if (go) begin
            seen_r <= wr_s;
            busy_r <= 1'b1;
            cnt_r <= 16'h0000;
        end else if (busy_r && cnt_r == CNT_LAST) begin
            busy_r <= 1'b0;
            done_r <= seen_r;
        end else if (busy_r) begin
            cnt_r <= cnt_r + CNT_STEP;
        end
    end
    // Array keeps its contents; no reset on purpose
    always_ff @(posedge clk_in) begin
        if (go) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (pif.page_mask[i]) begin
                    mem[{pif.page_row, 3'(i)}] <= pif.page_data[i];
                end
            end
        end
    end
    assign pif.rd_data = mem[pif.rd_addr];
    assign pif.done_tog = done_r;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_prog_busy_hold: assert property (go |=> busy_r [*8])
        else $error("programming cycle ended too early");
    a_prog_done_flip: assert property (
        $fell(busy_r) |-> done_r == seen_r && $past(cnt_r) == CNT_LAST)
        else $error("done toggle or cycle length wrong");
endmodule // sep_prog

/* verilog/sep_eeprom.sv */
// Purpose: Two-wire 256 x 8 non-volatile memory slave
// Assumes: Serial clock is the link clock and may stand still
// Notes: Start and stop are caught on data line edges
`timescale 1ns/1ns
module sep_eeprom #(
    parameter int WR_CYC = sep_pkg::WR_CYCLES
) (
    // System clock and reset
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    // Two-wire link
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N_OUT,
    // Straps
    input wire logic SELECT_PIN_BIT0_IN,
    input wire logic SELECT_PIN_BIT1_IN,
    input wire logic SELECT_PIN_BIT2_IN,
    input wire logic WRITE_PROTECT_IN
);
    import sep_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    sep_prog_if pif ();
    logic [SYNC_W-1:0] sync_q;
    logic start_tog_r;
    logic start_seen_r;
    logic wr_tog_r;
    sep_state_e state_r;
    sep_state_e state_nxt;
    logic [3:0] bit_cnt_r;
    logic [3:0] bit_cnt_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [7:0] addr_r;
    logic [7:0] addr_nxt;
    logic [7:0] tx_r;
    logic [7:0] tx_nxt;
    logic ack_r;
    logic ack_nxt;
    logic rw_r;
    logic rw_nxt;
    logic wr_arm_r;
    logic wr_arm_nxt;
    logic [7:0][7:0] page_r;
    logic [7:0][7:0] page_nxt;
    logic [7:0] mask_r;
    logic [7:0] mask_nxt;
    logic oe_n_r;
    logic sda_out_r;

    // ------------------------------------------------------------
    // Strap and status synchronisers
    // ------------------------------------------------------------
    sep_sync2 #(.W(SYNC_W)) u_link_sync (
        .clk_in(SCL_IN),
        .rst_in(SYS_RST_IN),
        .d_in({WRITE_PROTECT_IN, SELECT_PIN_BIT2_IN, SELECT_PIN_BIT1_IN,
               SELECT_PIN_BIT0_IN, wr_tog_r, pif.done_tog}),
        .q_out(sync_q)
    );
    wire wp_s = sync_q[5];
    wire [2:0] sel_s = sync_q[4:2];
    // Busy while a posted page has not come back as done
    wire busy_s = sync_q[1] ^ sync_q[0];

    // ------------------------------------------------------------
    // Programming engine
    // ------------------------------------------------------------
    sep_prog #(.WR_CYC(WR_CYC)) u_prog (
        .clk_in(MCLK_IN),
        .rst_in(SYS_RST_IN),
        .pif(pif.prog)
    );

    // ------------------------------------------------------------
    // Start and stop detection
    // ------------------------------------------------------------
    // Data edges act as clocks here; the clock line stands still
    // across a stop, so no link clock edge could see it
    always_ff @(negedge SDA_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            start_tog_r <= 1'b0;
        end else if (SCL_IN) begin
            start_tog_r <= ~start_tog_r;
        end
    end

    wire stop_commit = SCL_IN && wr_arm_r && !wp_s;

    // Stop posts the page only if data was taken and not protected
    always_ff @(posedge SDA_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            wr_tog_r <= 1'b0;
        end else if (stop_commit) begin
            wr_tog_r <= ~wr_tog_r;
        end
    end

    // ------------------------------------------------------------
    // Link decode
    // ------------------------------------------------------------
    wire new_start = start_tog_r != start_seen_r;
    wire [7:0] byte_in = {shift_r[6:0], SDA_IN};
    wire last_bit = bit_cnt_r == LAST_BIT;
    wire ack_clk = bit_cnt_r == ACK_BIT;
    wire type_ok = byte_in[7:4] == DEV_TYPE;
    wire sel_ok = byte_in[3:1] == sel_s;
    wire dev_match = type_ok && sel_ok && !busy_s;
    wire [7:0] addr_inc = addr_r + 8'h01;
    wire [2:0] low_inc = addr_r[2:0] + 3'h1;
    wire [7:0] addr_page_inc = {addr_r[7:3], low_inc};
    wire master_ack = !SDA_IN;
    wire rx_state = state_r == ST_DEVADDR || state_r == ST_WORDADDR
        || state_r == ST_WRDATA;
    wire store_byte = state_r == ST_WRDATA && last_bit && !new_start;
    wire [3:0] tx_idx = LAST_BIT - bit_cnt_r;
    wire tx_bit = tx_r[tx_idx[2:0]];
    // A start not yet clocked in must not leave an old bit on the line
    wire drive_ack = rx_state && ack_clk && ack_r && !new_start;
    wire drive_tx = state_r == ST_RDDATA && !ack_clk && !new_start;
    wire oe_n_nxt = drive_ack ? 1'b0 : (drive_tx ? tx_bit : 1'b1);

    // Prefetch the following byte while a read is running
    assign pif.rd_addr = (state_r == ST_RDDATA) ? addr_inc : addr_r;
    assign pif.page_data = page_r;
    assign pif.page_mask = mask_r;
    assign pif.page_row = addr_r[7:3];
    assign pif.wr_tog = wr_tog_r;

    // ------------------------------------------------------------
    // Link state machine
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        addr_nxt = addr_r;
        tx_nxt = tx_r;
        ack_nxt = ack_r;
        rw_nxt = rw_r;
        wr_arm_nxt = wr_arm_r;
        page_nxt = page_r;
        mask_nxt = mask_r;
        if (new_start) begin
            state_nxt = ST_DEVADDR;
            bit_cnt_nxt = 4'h1;
            shift_nxt = {7'h00, SDA_IN};
            ack_nxt = 1'b0;
            wr_arm_nxt = 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    bit_cnt_nxt = 4'h0;
                end
                ST_DEVADDR: begin
                    if (!ack_clk) begin
                        shift_nxt = byte_in;
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end
                    if (last_bit) begin
                        ack_nxt = dev_match;
                        rw_nxt = SDA_IN;
                    end
                    if (ack_clk) begin
                        bit_cnt_nxt = 4'h0;
                        if (!ack_r) begin
                            state_nxt = ST_IDLE;
                        end else if (rw_r) begin
                            state_nxt = ST_RDDATA;
                            tx_nxt = pif.rd_data;
                        end else begin
                            state_nxt = ST_WORDADDR;
                        end
                    end
                end
                ST_WORDADDR: begin
                    if (!ack_clk) begin
                        shift_nxt = byte_in;
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end
                    if (last_bit) begin
                        ack_nxt = 1'b1;
                    end
                    if (ack_clk) begin
                        bit_cnt_nxt = 4'h0;
                        // Dummy write of a random read ends here
                        addr_nxt = shift_r;
                        mask_nxt = 8'h00;
                        state_nxt = ST_WRDATA;
                    end
                end
                ST_WRDATA: begin
                    if (!ack_clk) begin
                        shift_nxt = byte_in;
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end
                    if (last_bit) begin
                        // Ninth byte onward overwrites within the page
                        ack_nxt = 1'b1;
                        page_nxt[addr_r[2:0]] = byte_in;
                        mask_nxt[addr_r[2:0]] = 1'b1;
                        addr_nxt = addr_page_inc;
                        wr_arm_nxt = 1'b1;
                    end
                    if (ack_clk) begin
                        bit_cnt_nxt = 4'h0;
                    end
                end
                ST_RDDATA: begin
                    if (!ack_clk) begin
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end else begin
                        bit_cnt_nxt = 4'h0;
                        addr_nxt = addr_inc;
                        if (master_ack) begin
                            tx_nxt = pif.rd_data;
                        end else begin
                            state_nxt = ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge SCL_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            start_seen_r <= 1'b0;
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            addr_r <= ADDR_RST;
            tx_r <= 8'h00;
            ack_r <= 1'b0;
            rw_r <= 1'b0;
        end else begin
            start_seen_r <= start_tog_r;
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            addr_r <= addr_nxt;
            tx_r <= tx_nxt;
            ack_r <= ack_nxt;
            rw_r <= rw_nxt;
        end
    end

    always_ff @(posedge SCL_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            wr_arm_r <= 1'b0;
            page_r <= '0;
            mask_r <= 8'h00;
        end else begin
            wr_arm_r <= wr_arm_nxt;
            page_r <= page_nxt;
            mask_r <= mask_nxt;
        end
    end

    // ------------------------------------------------------------
    // Open-drain driver
    // ------------------------------------------------------------
    // Changes only after the falling clock edge
    always_ff @(negedge SCL_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            oe_n_r <= OE_N_RST;
            sda_out_r <= 1'b0;
        end else begin
            oe_n_r <= oe_n_nxt;
            sda_out_r <= 1'b0;
        end
    end

    assign SDA_OE_N_OUT = oe_n_r;
    assign SDA_OUT = sda_out_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge SCL_IN); endclocking
    default disable iff (SYS_RST_IN);

    sequence s_dev_last;
        state_r == ST_DEVADDR && last_bit && !new_start;
    endsequence

    sequence s_ack_clock;
        ack_clk && !new_start;
    endsequence

    a_match_ack_low: assert property (
        s_dev_last ##0 dev_match |=> ack_r && !SDA_OE_N_OUT)
        else $error("matching device byte not acked");
    a_busy_no_ack: assert property (
        s_dev_last ##0 busy_s |=> !ack_r && SDA_OE_N_OUT)
        else $error("device acked while programming");
    a_mismatch_idle: assert property (
        state_r == ST_DEVADDR && !ack_r ##0 s_ack_clock
        |=> state_r == ST_IDLE)
        else $error("unacked device byte did not idle");
    a_read_dir: assert property (
        state_r == ST_DEVADDR && ack_r && rw_r ##0 s_ack_clock
        |=> state_r == ST_RDDATA && bit_cnt_r == 4'h0)
        else $error("read direction not taken");
    a_page_wrap: assert property (
        store_byte |=> addr_r ==
        {$past(addr_r[7:3]), $past(addr_r[2:0]) + 3'h1})
        else $error("write address left its page");
    a_read_inc: assert property (
        state_r == ST_RDDATA ##0 s_ack_clock
        |=> addr_r == $past(addr_r) + 8'h01)
        else $error("read address not advanced");
    a_tx_bit_out: assert property (
        drive_tx |-> SDA_OE_N_OUT == tx_bit)
        else $error("read data bit wrong on the line");
    a_idle_release: assert property (
        state_r == ST_IDLE |-> SDA_OE_N_OUT && SDA_OUT == 1'b0)
        else $error("line pulled while idle");
    a_start_restart: assert property (
        new_start |=> state_r == ST_DEVADDR && bit_cnt_r == 4'h1)
        else $error("start did not restart decoding");
    a_wp_no_post: assert property (@(posedge SDA_IN)
        disable iff (SYS_RST_IN) (SCL_IN && (wp_s || !wr_arm_r))
        |=> wr_tog_r == $past(wr_tog_r))
        else $error("page posted while protected or unarmed");
endmodule // sep_eeprom

/* tb/sep_master.sv */
// Purpose: Behavioural two-wire bus master facing the memory slave
// Assumes: Line has a pull-up; any agent may pull it low
// Notes: Serial clock of 80 ns stands still high between frames
`timescale 1ns/1ns
module sep_master (
    // Link
    output logic scl_out,
    output logic sda_oe_n_out,
    input wire logic sda_in
);
    localparam int Q = 20;
    initial begin
        scl_out = 1'b1;
        sda_oe_n_out = 1'b1;
    end
    // Data set while clock low, so only framing moves it while high
    task automatic bit_io(input logic b, output logic r);
        sda_oe_n_out = b;
        #Q scl_out = 1'b1;
        #Q r = sda_in;
        #Q scl_out = 1'b0;
        #Q;
    endtask
    task automatic start();
        sda_oe_n_out = 1'b1;
        #Q scl_out = 1'b1;
        #Q sda_oe_n_out = 1'b0;
        #Q scl_out = 1'b0;
        #Q;
    endtask
    task automatic stop();
        sda_oe_n_out = 1'b0;
        #Q scl_out = 1'b1;
        #Q sda_oe_n_out = 1'b1;
        #(3*Q);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // Released line reads high through the pull-up
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~mack, r);
    endtask
endmodule // sep_master

/* tb/tb.sv */
// Purpose: Self-checking bench of the two-wire memory slave
// Assumes: Short programming count of 20 system clocks
// Notes: Array model built from integers, counter kept alongside
`timescale 1ns/1ns
`define CHK(nm, e, g) \
    check_count++; \
    if (8'(g) !== 8'(e)) begin \
        $display("MISMATCH %s exp %0h got %0h", nm, 8'(e), 8'(g)); \
        bad_count++; \
    end
module tb;
    import sep_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wp = 1'b0;
    logic [2:0] sel = 3'h0;
    logic scl, m_oe_n, sda, dut_out, dut_oe_n, k;
    int seed = 32'hf86d;
    int mem [MEM_WORDS];
    int cnt = 0;
    int bad_count = 0;
    int check_count = 0;
    int pa [5] = '{8'h3e, 8'h40, 8'hf8, 8'h00, 8'h45};
    int pn [5] = '{10, 8, 8, 8, 1};
    always #50 clk = ~clk;
    // Wired line: low if any agent pulls
    assign sda = m_oe_n & (dut_oe_n | dut_out);
    sep_master m (.scl_out(scl), .sda_oe_n_out(m_oe_n), .sda_in(sda));
    sep_eeprom #(.WR_CYC(20)) dut (
        .MCLK_IN(clk), .SYS_RST_IN(rst), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(dut_out), .SDA_OE_N_OUT(dut_oe_n),
        .SELECT_PIN_BIT0_IN(sel[0]), .SELECT_PIN_BIT1_IN(sel[1]),
        .SELECT_PIN_BIT2_IN(sel[2]), .WRITE_PROTECT_IN(wp));
    // ------------------------------------------------------------
    // Line watchers
    // ------------------------------------------------------------
    always @(posedge scl) if (dut_oe_n === 1'b0) begin
        `CHK("pull only", 0, dut_out)
    end
    always @(dut_oe_n) if (rst === 1'b0) begin
        `CHK("moves on low clock", 0, scl)
    end
    // ------------------------------------------------------------
    // Transfers
    // ------------------------------------------------------------
    task automatic bad_dev(input logic [7:0] b);
        m.start();
        m.wbyte(b, k);
        `CHK("foreign nack", 0, k)
        m.stop();
    endtask
    task automatic wr_page(input int a, input int n);
        logic [7:0] d;
        m.start();
        m.wbyte({DEV_TYPE, sel, 1'b0}, k);
        `CHK("dev ack", 1, k)
        m.wbyte(8'(a), k);
        `CHK("word ack", 1, k)
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            m.wbyte(d, k);
            `CHK("data ack", 1, k)
            if (wp == 1'b0) mem[(a & 8'hf8) | ((a + i) & 7)] = d;
        end
        m.stop();
        cnt = (a & 8'hf8) | ((a + n) & 7);
    endtask
    task automatic poll(input int busy);
        int n;
        n = 0;
        k = 1'b0;
        while (k !== 1'b1 && n < 200) begin
            m.start();
            m.wbyte({DEV_TYPE, sel, 1'b0}, k);
            m.stop();
            n++;
        end
        `CHK("first poll refused", busy, n > 1)
        `CHK("poll acked", 1, k)
    endtask
    task automatic rd_seq(input int a, input int n);
        logic [7:0] d;
        if (a >= 0) begin
            m.start();
            m.wbyte({DEV_TYPE, sel, 1'b0}, k);
            m.wbyte(8'(a), k);
            cnt = a;
        end
        m.start();
        m.wbyte({DEV_TYPE, sel, 1'b1}, k);
        `CHK("read dev ack", 1, k)
        for (int i = 0; i < n; i++) begin
            m.rbyte(i < n - 1, d);
            `CHK("read data", mem[cnt], d)
            cnt = (cnt + 1) % MEM_WORDS;
        end
        m.stop();
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        #1000000;
        bad_count++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        sel = 3'($random(seed));
        @(posedge clk);
        #1;
        for (int j = 0; j < 3; j++) begin
            bad_dev({DEV_TYPE, sel ^ 3'(1 << j), 1'b0});
        end
        bad_dev({~DEV_TYPE, sel, 1'b1});
        $display("test foreign done");
        for (int j = 0; j < 5; j++) begin
            wr_page(pa[j], pn[j]);
            poll(1);
        end
        $display("test writes done");
        rd_seq(-1, 2);
        rd_seq(8'h3c, 9);
        rd_seq(8'hfe, 4);
        $display("test reads done");
        @(posedge clk);
        #1 wp = 1'b1;
        wr_page(8'h40, 3);
        poll(0);
        @(posedge clk);
        #1 wp = 1'b0;
        rd_seq(8'h40, 3);
        $display("test protect done");
        // Cut a data byte short: nothing may be programmed
        m.start();
        m.wbyte({DEV_TYPE, sel, 1'b0}, k);
        m.wbyte(8'h42, k);
        for (int j = 0; j < 4; j++) begin
            m.bit_io(1'b0, k);
        end
        cnt = 8'h42;
        rd_seq(-1, 1);
        poll(0);
        $display("test abandon done");
        stop_test();
    end
endmodule // tb
